// *** verilog/uls_line_status.v ***
// UART receiver framing and line status flags with clear-on-read register
`timescale 1ns/100ps
`include "uls_consts.vh"
module uls_line_status (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [31:0] reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [15:0] reg_rdata,
  input  wire        serial_in,
  input  wire        infrared_serial_in,
  input  wire        baud_tick,
  input  wire        tx_shift_empty,
  input  wire        tx_holding_full,
  input  wire [4:0]  tx_fifo_count,
  output wire        thre_int_req,
  output wire [15:0] line_status
);
  localparam [6:0] ST_IDLE   = 7'h01;
  localparam [6:0] ST_START  = 7'h02;
  localparam [6:0] ST_DATA   = 7'h04;
  localparam [6:0] ST_PARITY = 7'h08;
  localparam [6:0] ST_STOP   = 7'h10;
  localparam [6:0] ST_BREAK  = 7'h20;
  localparam [6:0] ST_WAITHI = 7'h40;

  function [7:0] char_ticks;
    input [1:0] dls;
    input       parity_enable;
    input       stop2;
    reg   [3:0] bits;
    begin
      bits       = 4'h2 + `ULS_MIN_BITS + {2'b00, dls} + {3'b000, parity_enable} + {3'b000, stop2};
      char_ticks = {bits, 4'h0};
    end
  endfunction

  function [7:0] align;
    input [7:0] shift;
    input [1:0] dls;
    begin
      align = shift >> (2'd3 - dls);
    end
  endfunction

  function par_err;
    input [7:0] data;
    input       pbit;
    input       even;
    input       parity_enable;
    begin
      par_err = parity_enable & ((^data) ^ pbit ^ ~even);
    end
  endfunction

  function [4:0] trg_level;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   trg_level = `ULS_TRG_EMPTY;
        2'b01:   trg_level = `ULS_TRG_TWO;
        2'b10:   trg_level = `ULS_TRG_QUARTER;
        default: trg_level = `ULS_TRG_HALF;
      endcase
    end
  endfunction

  reg  [15:0] cfg_r;
  reg  [15:0] rdata_r;
  reg  [2:0]  sin_sync_r;
  reg  [2:0]  sir_sync_r;
  reg         sin_filt_r;
  reg         sir_filt_r;
  reg  [4:0]  ir_hold_r;
  reg  [7:0]  brk_cnt_r;
  reg  [6:0]  state_r;
  reg  [3:0]  tick_r;
  reg  [2:0]  bit_r;
  reg  [7:0]  shift_r;
  reg         par_r;
  reg         done_r;
  reg  [7:0]  done_data_r;
  reg  [2:0]  done_err_r;
  reg  [7:0]  rxb_r;
  reg         rxb_valid_r;
  reg         new_head_r;
  reg         oe_r;
  reg         pe_r;
  reg         fe_r;
  reg         bi_r;
  reg         rfe_r;
  reg         thre_r;
  reg         temt_r;
  reg         thre_irq_r;
  reg  [2:0]  err_set;
  wire        fifo_en;
  wire        parity_enable;
  wire [1:0]  dls;
  wire        rx_line;
  wire        brk_long;
  wire [7:0]  data_a;
  wire        sts_rd;
  wire        rxb_rd;
  wire        cfg_wr;
  wire        fifo_push;
  wire        fifo_pop;
  wire [10:0] head_data;
  wire        fifo_empty;
  wire        fifo_full;
  wire        tail_err;
  wire        ovr_set;
  wire        rfe_set;
  wire        dr;
  wire        tx_fifo_empty;
  wire [15:0] sts_value;

  assign fifo_en = cfg_r[`ULS_CFG_FIFO_EN];
  assign parity_enable     = cfg_r[`ULS_CFG_PAR_EN];
  assign dls     = cfg_r[`ULS_CFG_DLS_HI:`ULS_CFG_DLS_LO];
  assign sts_rd  = reg_rd & (reg_addr == `ULS_ADDR_LINE_STATUS);
  assign rxb_rd  = reg_rd & (reg_addr == `ULS_ADDR_RX_BUFFER);
  assign cfg_wr  = reg_wr & (reg_addr == `ULS_ADDR_LINE_CFG);

  // Pin inputs: a new level counts only once the second and third stages agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sin_sync_r <= {3{`ULS_LINE_IDLE}};
      sir_sync_r <= {3{`ULS_LINE_IDLE}};
      sin_filt_r <= `ULS_LINE_IDLE;
      sir_filt_r <= `ULS_LINE_IDLE;
    end else begin
      sin_sync_r <= {sin_sync_r[1:0], serial_in};
      sir_sync_r <= {sir_sync_r[1:0], infrared_serial_in};
      if (sin_sync_r[1] == sin_sync_r[2])
        sin_filt_r <= sin_sync_r[2];
      if (sir_sync_r[1] == sir_sync_r[2])
        sir_filt_r <= sir_sync_r[2];
    end
  end

  // Infrared pulses are stretched to a bit period so a pulse train reads as low
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ir_hold_r <= 5'h00;
    else if (!sir_filt_r)
      ir_hold_r <= `ULS_IR_STRETCH;
    else if (baud_tick && (ir_hold_r != 5'h00))
      ir_hold_r <= ir_hold_r - 5'h01;
  end

  assign rx_line = cfg_r[`ULS_CFG_IR_EN] ? (ir_hold_r == 5'h00) : sin_filt_r;

  // Low time counted in oversample ticks, saturating
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      brk_cnt_r <= 8'h00;
    else if (rx_line)
      brk_cnt_r <= 8'h00;
    else if (baud_tick && (brk_cnt_r != `ULS_BRK_MAX))
      brk_cnt_r <= brk_cnt_r + 8'h01;
  end

  assign brk_long = brk_cnt_r > char_ticks(dls, parity_enable, cfg_r[`ULS_CFG_STOP2]);
  assign data_a   = align(shift_r, dls);

  // Receive framer, sixteen ticks per bit, sampling at mid-bit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= ST_IDLE;
      tick_r      <= 4'h0;
      bit_r       <= 3'h0;
      shift_r     <= 8'h00;
      par_r       <= 1'b0;
      done_r      <= 1'b0;
      done_data_r <= 8'h00;
      done_err_r  <= `ULS_ERR_NONE;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          tick_r <= 4'h0;
          if (!rx_line)
            state_r <= ST_START;
        end
        ST_START: begin
          if (baud_tick) begin
            tick_r <= tick_r + 4'h1;
            if (tick_r == `ULS_TICK_MID) begin
              tick_r  <= 4'h0;
              bit_r   <= 3'h0;
              state_r <= rx_line ? ST_IDLE : ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (baud_tick) begin
            tick_r <= tick_r + 4'h1;
            if (tick_r == `ULS_TICK_LAST) begin
              shift_r <= {rx_line, shift_r[7:1]};
              bit_r   <= bit_r + 3'h1;
              if (bit_r == {1'b1, dls})
                state_r <= parity_enable ? ST_PARITY : ST_STOP;
            end
          end
        end
        ST_PARITY: begin
          if (baud_tick) begin
            tick_r <= tick_r + 4'h1;
            if (tick_r == `ULS_TICK_LAST) begin
              par_r   <= rx_line;
              state_r <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (baud_tick) begin
            tick_r <= tick_r + 4'h1;
            if (tick_r == `ULS_TICK_LAST) begin
              if (rx_line) begin
                done_r      <= 1'b1;
                done_data_r <= data_a;
                done_err_r  <= {2'b00, par_err(data_a, par_r, cfg_r[`ULS_CFG_PAR_EVEN], parity_enable)};
                state_r     <= ST_IDLE;
              end else if ((data_a == 8'h00) && !(parity_enable && par_r)) begin
                // All-zero frame may be a break; hold it until the low time decides
                state_r <= ST_BREAK;
              end else begin
                done_r      <= 1'b1;
                done_data_r <= data_a;
                done_err_r  <= {2'b01, par_err(data_a, par_r, cfg_r[`ULS_CFG_PAR_EVEN], parity_enable)};
                tick_r      <= 4'h0;
                bit_r       <= 3'h0;
                state_r     <= ST_DATA;
              end
            end
          end
        end
        ST_BREAK: begin
          if (brk_long) begin
            done_r      <= 1'b1;
            done_data_r <= 8'h00;
            done_err_r  <= `ULS_ERR_BRK;
            state_r     <= ST_WAITHI;
          end else if (rx_line) begin
            done_r      <= 1'b1;
            done_data_r <= 8'h00;
            done_err_r  <= {2'b01, par_err(8'h00, par_r, cfg_r[`ULS_CFG_PAR_EVEN], parity_enable)};
            state_r     <= ST_IDLE;
          end
        end
        ST_WAITHI: begin
          // No further characters until the line returns high
          if (rx_line)
            state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign fifo_push = done_r & fifo_en & ~fifo_full;
  assign fifo_pop  = rxb_rd & fifo_en & ~fifo_empty;
  assign ovr_set   = done_r & (fifo_en ? fifo_full : (rxb_valid_r & ~rxb_rd));
  assign rfe_set   = fifo_push & (|done_err_r);

  uls_rx_fifo u_rx_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .clear     (~fifo_en),
    .push      (fifo_push),
    .push_data ({done_err_r, done_data_r}),
    .pop       (fifo_pop),
    .head_data (head_data),
    .empty     (fifo_empty),
    .full      (fifo_full),
    .tail_err  (tail_err)
  );

  // Error bits reach the flags at once without FIFOs, at the head with them
  always @* begin
    err_set = `ULS_ERR_NONE;
    if (done_r && !fifo_en)
      err_set = done_err_r;
    else if (new_head_r && fifo_en && !fifo_empty)
      err_set = head_data[10:8];
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxb_r       <= 8'h00;
      rxb_valid_r <= 1'b0;
      new_head_r  <= 1'b0;
      oe_r        <= `ULS_FLAG_RST;
      pe_r        <= `ULS_FLAG_RST;
      fe_r        <= `ULS_FLAG_RST;
      bi_r        <= `ULS_FLAG_RST;
      rfe_r       <= `ULS_FLAG_RST;
    end else begin
      if (done_r && !fifo_en)
        rxb_r <= done_data_r;
      // Set wins over the clear of the same cycle
      rxb_valid_r <= ~fifo_en & ((rxb_valid_r & ~rxb_rd) | done_r);
      new_head_r  <= fifo_pop | (fifo_push & fifo_empty);
      oe_r  <= (oe_r & ~sts_rd) | ovr_set;
      pe_r  <= (pe_r & ~sts_rd) | err_set[`ULS_ERR_PE];
      fe_r  <= (fe_r & ~sts_rd) | err_set[`ULS_ERR_FE];
      bi_r  <= (bi_r & ~sts_rd) | err_set[`ULS_ERR_BI];
      rfe_r <= fifo_en & ((rfe_r & ~(sts_rd & ~tail_err)) | rfe_set);
    end
  end

  assign dr            = fifo_en ? ~fifo_empty : rxb_valid_r;
  assign tx_fifo_empty = (tx_fifo_count == 5'h00);

  // Transmit side flags follow the transmitter state every cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thre_r     <= `ULS_THRE_RST;
      temt_r     <= `ULS_TEMT_RST;
      thre_irq_r <= 1'b0;
    end else begin
      temt_r <= tx_shift_empty & (fifo_en ? tx_fifo_empty : ~tx_holding_full);
      if (cfg_r[`ULS_CFG_THRE_MODE] && fifo_en) begin
        thre_r     <= (tx_fifo_count == `ULS_TX_FULL);
        thre_irq_r <= (tx_fifo_count <= trg_level(cfg_r[`ULS_CFG_TRG_HI:`ULS_CFG_TRG_LO]));
      end else begin
        thre_r     <= fifo_en ? tx_fifo_empty : ~tx_holding_full;
        thre_irq_r <= fifo_en ? tx_fifo_empty : ~tx_holding_full;
      end
    end
  end

  assign sts_value = {8'h00, rfe_r, temt_r, thre_r, bi_r, fe_r, pe_r, oe_r, dr};

  // Register port; read data valid only in the cycle after the strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r   <= `ULS_CFG_RST;
      rdata_r <= 16'h0000;
    end else begin
      if (cfg_wr)
        cfg_r <= reg_wdata & `ULS_CFG_MASK;
      rdata_r <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          `ULS_ADDR_LINE_STATUS: rdata_r <= sts_value;
          `ULS_ADDR_RX_BUFFER:   rdata_r <= {8'h00, fifo_en ? head_data[7:0] : rxb_r};
          `ULS_ADDR_LINE_CFG:    rdata_r <= cfg_r;
          default:               rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  assign reg_rdata    = rdata_r;
  assign thre_int_req = thre_irq_r;
  assign line_status  = sts_value;
endmodule

// *** verilog/uls_consts.vh ***
// Constants shared by the line status block and its receive FIFO
`ifndef ULS_CONSTS_VH
`define ULS_CONSTS_VH

// Register byte addresses
`define ULS_ADDR_RX_BUFFER   32'h50001100
`define ULS_ADDR_LINE_STATUS 32'h50001114
`define ULS_ADDR_LINE_CFG    32'h50001140

// Line status bit positions
`define ULS_LS_DR   0
`define ULS_LS_OE   1
`define ULS_LS_PE   2
`define ULS_LS_FE   3
`define ULS_LS_BI   4
`define ULS_LS_THRE 5
`define ULS_LS_TEMT 6
`define ULS_LS_RFE  7

// Reset values
`define ULS_THRE_RST  1'b1
`define ULS_TEMT_RST  1'b1
`define ULS_FLAG_RST  1'b0
`define ULS_CFG_RST   16'h0000
`define ULS_CFG_MASK  16'h03ff
`define ULS_LINE_IDLE 1'b1

// Line configuration bit positions
`define ULS_CFG_FIFO_EN   0
`define ULS_CFG_PAR_EN    1
`define ULS_CFG_PAR_EVEN  2
`define ULS_CFG_STOP2     3
`define ULS_CFG_DLS_LO    4
`define ULS_CFG_DLS_HI    5
`define ULS_CFG_IR_EN     6
`define ULS_CFG_THRE_MODE 7
`define ULS_CFG_TRG_LO    8
`define ULS_CFG_TRG_HI    9

// Error bits carried with each received character
`define ULS_ERR_PE   0
`define ULS_ERR_FE   1
`define ULS_ERR_BI   2
`define ULS_ERR_NONE 3'h0
`define ULS_ERR_BRK  3'h7

// FIFO geometry
`define ULS_FIFO_AW    4
`define ULS_FIFO_DEPTH 5'h10
`define ULS_FIFO_W     11
`define ULS_TX_FULL    5'h10

// Transmit FIFO threshold levels
`define ULS_TRG_EMPTY   5'h00
`define ULS_TRG_TWO     5'h02
`define ULS_TRG_QUARTER 5'h04
`define ULS_TRG_HALF    5'h08

// Oversampling
`define ULS_TICK_MID  4'h7
`define ULS_TICK_LAST 4'hf
`define ULS_IR_STRETCH 5'h10
`define ULS_BRK_MAX   8'hff
`define ULS_MIN_BITS  4'h5

`endif

// *** verilog/uls_rx_fifo.v ***
// Receive FIFO holding characters with their error bits
`timescale 1ns/100ps
`include "uls_consts.vh"
module uls_rx_fifo (
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire                   clear,
  input  wire                   push,
  input  wire [`ULS_FIFO_W-1:0] push_data,
  input  wire                   pop,
  output wire [`ULS_FIFO_W-1:0] head_data,
  output wire                   empty,
  output wire                   full,
  output reg                    tail_err
);
  reg [`ULS_FIFO_W-1:0]  mem_r [0:`ULS_FIFO_DEPTH-1];
  reg [`ULS_FIFO_AW-1:0] wr_ptr_r;
  reg [`ULS_FIFO_AW-1:0] rd_ptr_r;
  reg [`ULS_FIFO_AW:0]   count_r;
  reg [`ULS_FIFO_AW-1:0] idx;
  wire                   do_push;
  wire                   do_pop;
  integer                i;

  assign empty     = (count_r == 5'h00);
  assign full      = (count_r == `ULS_FIFO_DEPTH);
  assign head_data = mem_r[rd_ptr_r];
  // A push into a full FIFO is dropped so the stored characters stay intact
  assign do_push   = push & ~full;
  assign do_pop    = pop & ~empty;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= 4'h0;
      rd_ptr_r <= 4'h0;
      count_r  <= 5'h00;
    end else if (clear) begin
      wr_ptr_r <= 4'h0;
      rd_ptr_r <= 4'h0;
      count_r  <= 5'h00;
    end else begin
      if (do_push)
        wr_ptr_r <= wr_ptr_r + 4'h1;
      if (do_pop)
        rd_ptr_r <= rd_ptr_r + 4'h1;
      if (do_push && !do_pop)
        count_r <= count_r + 5'h01;
      else if (do_pop && !do_push)
        count_r <= count_r - 5'h01;
    end
  end

  always @(posedge clk) begin
    if (do_push)
      mem_r[wr_ptr_r] <= push_data;
  end

  // Errors in any entry behind the head
  always @* begin
    tail_err = 1'b0;
    idx      = 4'h0;
    for (i = 1; i < `ULS_FIFO_DEPTH; i = i + 1) begin
      idx = rd_ptr_r + i[3:0];
      if ((i[4:0] < count_r) && (|mem_r[idx][`ULS_FIFO_W-1:8]))
        tail_err = 1'b1;
    end
  end
endmodule

// *** test/uls_line_status_asserts.sv ***
// Port checker of the line status block
`timescale 1ns/100ps
`include "uls_consts.vh"
module uls_line_status_asserts (
  input wire        clk,
  input wire        rst_n,
  input wire [31:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        tx_shift_empty,
  input wire        tx_holding_full,
  input wire [4:0]  tx_fifo_count,
  input wire        thre_int_req,
  input wire [15:0] line_status
);
  reg  [9:0] cfg_r;
  reg  [2:0] age_r;
  reg        temt_r;
  reg        thre_r;
  reg        int_r;
  wire       cfg_wr   = reg_wr && reg_addr == `ULS_ADDR_LINE_CFG;
  wire       buf_rd   = reg_rd && reg_addr == `ULS_ADDR_RX_BUFFER;
  wire       thm      = cfg_r[0] & cfg_r[7];
  wire       tx_empty = cfg_r[0] ? (tx_fifo_count == 5'h00) : !tx_holding_full;
  wire [4:0] lvl      = (cfg_r[9:8] == 2'h0) ? 5'h00 : (5'h01 << cfg_r[9:8]);

  // Mirrors the config register so the transmit flags can be predicted
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r  <= 10'h000;
      age_r  <= 3'h7;
      temt_r <= 1'b1;
      thre_r <= 1'b1;
      int_r  <= 1'b0;
    end else begin
      if (cfg_wr) begin
        cfg_r <= reg_wdata[9:0];
      end
      temt_r <= tx_shift_empty & tx_empty;
      thre_r <= thm ? (tx_fifo_count == 5'h10) : tx_empty;
      int_r  <= thm ? (tx_fifo_count <= lvl) : tx_empty;
      if (buf_rd || cfg_wr) begin
        age_r <= 3'h0;
      end else if (age_r != 3'h7) begin
        age_r <= age_r + 3'h1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_ls_read;
    reg_rd && reg_addr == `ULS_ADDR_LINE_STATUS;
  endsequence
  sequence s_sticky_drop;
    (|($past(line_status[4:1]) & ~line_status[4:1]));
  endsequence

  property p_read_value;
    s_ls_read |=> reg_rdata == $past(line_status);
  endproperty
  a_read_value: assert property (p_read_value)
    else $error("status read did not return the pre-clear value");
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read answer");
  property p_sticky;
    s_sticky_drop |-> $past(reg_rd && reg_addr == `ULS_ADDR_LINE_STATUS);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("error flag fell without a status read");
  property p_break;
    $rose(line_status[4]) |-> line_status[3:2] == 2'b11;
  endproperty
  a_break: assert property (p_break)
    else $error("break without framing and parity flags");
  property p_temt;
    line_status[6] == temt_r;
  endproperty
  a_temt: assert property (p_temt)
    else $error("transmitter empty flag wrong");
  property p_thre;
    line_status[5] == thre_r;
  endproperty
  a_thre: assert property (p_thre)
    else $error("holding empty flag wrong");
  property p_int;
    thre_int_req == int_r;
  endproperty
  a_int: assert property (p_int)
    else $error("holding empty request wrong");
  property p_dr_fall;
    $fell(line_status[0]) |-> age_r <= 3'h3;
  endproperty
  a_dr_fall: assert property (p_dr_fall)
    else $error("data ready fell without a buffer read");
  property p_reserved;
    line_status[15:8] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status bits not zero");
endmodule

// *** test/uls_remote_dev.sv ***
// Behavioural remote serial device on the plain and infrared lines
`timescale 1ns/100ps
module uls_remote_dev (
  input  wire  clk,
  input  wire  baud_tick,
  output logic ser_o,
  output logic ir_o
);
  // Both lines idle high, as with a pull-up
  initial begin
    ser_o = 1'b1;
    ir_o  = 1'b1;
  end
  task automatic ticks(input int n);
    repeat (n) do @(posedge clk); while (!baud_tick);
  endtask
  // Infrared sends a zero as a short low pulse, the receiver stretches it
  task automatic bit_out(input logic b, input logic ir);
    if (ir) begin
      ir_o <= b;
      ticks(3);
      ir_o <= 1'b1;
      ticks(13);
    end else begin
      ser_o <= b;
      ticks(16);
    end
  endtask
  // Eight data bits LSB first, even parity, chosen stop level, one idle bit
  task automatic send(input logic [7:0] d, input logic parity_enable, input logic bad,
                      input logic stp, input logic ir);
    bit_out(1'b0, ir);
    for (int i = 0; i < 8; i++) bit_out(d[i], ir);
    if (parity_enable) bit_out(^d ^ bad, ir);
    bit_out(stp, ir);
    bit_out(1'b1, ir);
  endtask
  // Five data bits, odd parity, two stop bits and one idle bit on the plain line
  task automatic send5(input logic [4:0] d, input logic bad);
    bit_out(1'b0, 1'b0);
    for (int i = 0; i < 5; i++) bit_out(d[i], 1'b0);
    bit_out(~^d ^ bad, 1'b0);
    repeat (3) bit_out(1'b1, 1'b0);
  endtask
  task automatic brk(input int n, input logic ir);
    repeat (n) bit_out(1'b0, ir);
  endtask
  task automatic idle(input int n);
    repeat (n) bit_out(1'b1, 1'b0);
  endtask
endmodule

// *** test/uls_line_status_tb.sv ***
// Self-checking testbench of the line status block
`timescale 1ns/100ps
`include "uls_consts.vh"
module uls_line_status_tb;
  localparam logic [31:0] LS = `ULS_ADDR_LINE_STATUS;
  localparam logic [31:0] RB = `ULS_ADDR_RX_BUFFER;
  localparam logic [31:0] CF = `ULS_ADDR_LINE_CFG;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        baud_tick = 1'b0;
  logic        tx_shift_empty = 1'b1;
  logic        tx_holding_full = 1'b0;
  logic [4:0]  tx_fifo_count = 5'h00;
  wire  [15:0] reg_rdata;
  wire  [15:0] line_status;
  wire         thre_int_req;
  wire         serial_in;
  wire         infrared_serial_in;
  logic [15:0] exp_q[$];
  logic [15:0] exp_v;
  logic        rd_seen = 1'b0;
  int          err_count = 0;
  int          total_checks = 0;
  logic [7:0]  d0;
  logic [7:0]  d1;
  logic [7:0]  chars[17];
  logic [4:0]  c;
  logic        h;
  logic        s;
  logic        emp;
  logic [15:0] cfgs[7] = '{16'h0000, 16'h0001, 16'h0081, 16'h0181, 16'h0281, 16'h0381,
                           16'h0080};

  uls_line_status u_uls_line_status (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_in(serial_in), .infrared_serial_in(infrared_serial_in), .baud_tick(baud_tick),
    .tx_shift_empty(tx_shift_empty), .tx_holding_full(tx_holding_full),
    .tx_fifo_count(tx_fifo_count), .thre_int_req(thre_int_req), .line_status(line_status));
  uls_remote_dev u_remote (.clk(clk), .baud_tick(baud_tick), .ser_o(serial_in),
    .ir_o(infrared_serial_in));

  initial begin
    forever #2.5 clk = ~clk;
  end
  // Oversample tick every second cycle keeps a character near 320 cycles
  always @(posedge clk) begin
    baud_tick <= ~baud_tick;
  end

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_seen <= reg_rd;
    if (rd_seen) begin
      exp_v = exp_q.pop_front();
      total_checks++;
      if (reg_rdata !== exp_v) begin
        err_count++;
        $display("[ERR] %0t read %h expected %h", $time, reg_rdata, exp_v);
      end
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    void'($urandom(51));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(LS, 16'h0060);
    rd(32'h50001118, 16'h0000);
    wr(LS, 16'hffff);
    rd(LS, 16'h0060);
    foreach (cfgs[k]) begin
      wr(CF, cfgs[k]);
      rd(CF, cfgs[k]);
      repeat (6) begin
        @(posedge clk);
        c = ($urandom % 4 == 0) ? 5'h10 : 5'($urandom % 17);
        h = 1'($urandom);
        s = 1'($urandom);
        tx_fifo_count   <= c;
        tx_holding_full <= h;
        tx_shift_empty  <= s;
        emp = cfgs[k][0] ? (c == 5'h00) : !h;
        rd(LS, {9'h0, s & emp, (cfgs[k][0] & cfgs[k][7]) ? (c == 5'h10) : emp, 5'h0});
      end
    end
    tx_fifo_count   <= 5'h00;
    tx_holding_full <= 1'b0;
    tx_shift_empty  <= 1'b1;
    wr(CF, 16'h0030);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    u_remote.send(d0, 1'b0, 1'b0, 1'b1, 1'b0);
    rd(LS, 16'h0061);
    rd(RB, {8'h00, d0});
    rd(LS, 16'h0060);
    u_remote.send(d0, 1'b0, 1'b0, 1'b1, 1'b0);
    u_remote.send(d1, 1'b0, 1'b0, 1'b1, 1'b0);
    rd(LS, 16'h0063);
    rd(LS, 16'h0061);
    rd(RB, {8'h00, d1});
    // A low stop bit restarts the receiver, the high line then reads as all ones
    u_remote.send(d0 | 8'h01, 1'b0, 1'b0, 1'b0, 1'b0);
    u_remote.idle(12);
    rd(LS, 16'h006b);
    rd(RB, 16'h00ff);
    rd(LS, 16'h0060);
    u_remote.brk(14, 1'b0);
    u_remote.idle(2);
    rd(LS, 16'h007d);
    rd(RB, 16'h0000);
    rd(LS, 16'h0060);
    wr(CF, 16'h0036);
    u_remote.send(d1, 1'b1, 1'b1, 1'b1, 1'b0);
    rd(LS, 16'h0065);
    rd(RB, {8'h00, d1});
    u_remote.send(d0, 1'b1, 1'b0, 1'b1, 1'b0);
    rd(LS, 16'h0061);
    rd(RB, {8'h00, d0});
    wr(CF, 16'h0070);
    u_remote.send(d1, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(RB, {8'h00, d1});
    u_remote.brk(14, 1'b1);
    u_remote.idle(2);
    rd(LS, 16'h007d);
    rd(RB, 16'h0000);
    rd(LS, 16'h0060);
    wr(CF, 16'h0031);
    for (int i = 0; i < 17; i++) begin
      chars[i] = 8'($urandom);
      u_remote.send(chars[i], 1'b0, 1'b0, 1'b1, 1'b0);
    end
    rd(LS, 16'h0063);
    for (int i = 0; i < 16; i++) rd(RB, {8'h00, chars[i]});
    rd(LS, 16'h0060);
    // Errored character sits between two good ones
    wr(CF, 16'h0037);
    u_remote.send(d0, 1'b1, 1'b0, 1'b1, 1'b0);
    u_remote.send(d1, 1'b1, 1'b1, 1'b1, 1'b0);
    u_remote.send(d0, 1'b1, 1'b0, 1'b1, 1'b0);
    rd(LS, 16'h00e1);
    rd(RB, {8'h00, d0});
    repeat (3) @(posedge clk);
    rd(LS, 16'h00e5);
    rd(LS, 16'h0061);
    rd(RB, {8'h00, d1});
    rd(RB, {8'h00, d0});
    rd(LS, 16'h0060);
    u_remote.send(d1, 1'b1, 1'b0, 1'b1, 1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(LS, 16'h0060);
    rd(CF, 16'h0000);
    // Short characters with odd parity and two stop bits, good then bad parity
    wr(CF, 16'h000a);
    u_remote.send5(d0[4:0], 1'b0);
    rd(LS, 16'h0061);
    rd(RB, {11'h000, d0[4:0]});
    u_remote.send5(d1[4:0], 1'b1);
    rd(LS, 16'h0065);
    rd(RB, {11'h000, d1[4:0]});
    repeat (4) @(posedge clk);
    wrap_up();
  end
endmodule

bind uls_line_status uls_line_status_asserts u_asserts (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .tx_shift_empty(tx_shift_empty), .tx_holding_full(tx_holding_full),
  .tx_fifo_count(tx_fifo_count), .thre_int_req(thre_int_req), .line_status(line_status));
